//--- ecp_device.sv
`default_nettype none
module ecp_device #(
  parameter int DATA_ROWS  = 128,
  parameter int OSC_LAYOUT = 0
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  ecp_link_if.dev          LINK,
  output var  logic        CLK_SWITCH_EN,
  output var  logic        FAIL_SAFE_EN,
  output var  logic [1:0]  STARTUP_SOURCE,
  output var  logic [3:0]  PRIMARY_MODE,
  output var  logic        PLL_X16,
  output var  logic        SECOND_OSC_OUT,
  output var  logic        SECOND_OSC_OE_N,
  output var  logic        CODE_PROTECTED
);
  logic [15:0] data_store [ecp_pkg::PANEL_WORDS];
  logic [15:0] code_mem [ecp_pkg::CODE_WORDS];
  logic [15:0] cfg [ecp_pkg::CFG_WORDS];
  ecp_pkg::ecp_dstate_e state;
  logic [6:0]  row;
  logic [3:0]  beat;
  logic        row_ok;
  logic [1:0]  div;
  logic        protect;
  logic [15:0] osc;
  logic [1:0]  sw_field;
  ecp_pkg::ecp_pmode_e next_mode;
  logic        cmd_pm;
  logic [2:0]  cidx;

  assign protect = ~cfg[ecp_pkg::CFG_PROTECT][ecp_pkg::PROTECT_BIT];
  assign osc     = cfg[ecp_pkg::CFG_OSC];
  assign sw_field = osc[ecp_pkg::SWITCH_LSB +: 2];
  assign cmd_pm  = LINK.cmd_op == ecp_pkg::OP_PM_READ || LINK.cmd_op == ecp_pkg::OP_PM_WRITE;
  assign cidx    = LINK.cmd_addr[2:0];

  // command engine: row collection and single answers
  always_ff @(posedge SYS_CLK)
  begin
    LINK.rsp_valid <= 1'b0;
    if (!RESET_N)
    begin
      state         <= ecp_pkg::D_IDLE;
      row           <= '0;
      beat          <= '0;
      row_ok        <= 1'b0;
      LINK.rsp_ok   <= 1'b0;
      LINK.rsp_data <= '0;
    end
    else if (state == ecp_pkg::D_ROW)
    begin
      if (LINK.wd_valid)
      begin
        if (row_ok)
          data_store[{row, beat}] <= LINK.wd_data;
        beat <= beat + 4'h1;
        if (beat == ecp_pkg::LAST_BEAT)
        begin
          state          <= ecp_pkg::D_IDLE;
          LINK.rsp_valid <= 1'b1;
          LINK.rsp_ok    <= row_ok;
          LINK.rsp_data  <= '0;
        end
      end
    end
    else if (LINK.cmd_valid)
    begin
      LINK.rsp_valid <= LINK.cmd_op != ecp_pkg::OP_ROW_PROG;
      LINK.rsp_ok    <= 1'b1;
      LINK.rsp_data  <= '0;
      if (cmd_pm && protect)
        LINK.rsp_ok <= 1'b0;
      else
        case (LINK.cmd_op)
          ecp_pkg::OP_ROW_PROG:
          begin
            state  <= ecp_pkg::D_ROW;
            row    <= LINK.cmd_addr[11:5];
            beat   <= '0;
            row_ok <= int'(LINK.cmd_addr[11:5]) < DATA_ROWS;
          end
          ecp_pkg::OP_DATA_READ:
            if (int'(LINK.cmd_addr[11:5]) < DATA_ROWS)
              LINK.rsp_data <= data_store[LINK.cmd_addr[11:1]];
            else
              LINK.rsp_ok <= 1'b0;
          ecp_pkg::OP_PM_READ:
            LINK.rsp_data <= code_mem[LINK.cmd_addr[8:1]];
          ecp_pkg::OP_PM_WRITE:
            code_mem[LINK.cmd_addr[8:1]] <= LINK.cmd_data;
          ecp_pkg::OP_CFG_READ:
            if (int'(cidx) < ecp_pkg::CFG_WORDS)
              LINK.rsp_data <= cfg[cidx];
            else
              LINK.rsp_ok <= 1'b0;
          ecp_pkg::OP_CFG_ERASE, ecp_pkg::OP_CFG_WRITE:
            if (int'(cidx) >= ecp_pkg::CFG_WORDS)
              LINK.rsp_ok <= 1'b0;
          default:
            LINK.rsp_ok <= 1'b0;
        endcase
    end
  end

  // seven configuration words, erased state all ones
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      for (int i = 0; i < ecp_pkg::CFG_WORDS; i++)
        cfg[i] <= ecp_pkg::CFG_ERASED;
    end
    else if (state == ecp_pkg::D_IDLE && LINK.cmd_valid && int'(cidx) < ecp_pkg::CFG_WORDS)
    begin
      if (LINK.cmd_op == ecp_pkg::OP_CFG_ERASE)
        cfg[cidx] <= ecp_pkg::CFG_ERASED;
      else if (LINK.cmd_op == ecp_pkg::OP_CFG_WRITE)
        cfg[cidx] <= LINK.cmd_data;
    end
  end

  // primary oscillator mode decode, per layout
  always_comb
  begin
    next_mode = ecp_pkg::PM_OTHER;
    if (OSC_LAYOUT == ecp_pkg::LAYOUT_WIDE)
      case (osc[ecp_pkg::MODE_LSB +: 5])
        ecp_pkg::MODE5_EXT_IO:  next_mode = ecp_pkg::PM_EXT_IO;
        ecp_pkg::MODE5_EXT_OUT: next_mode = ecp_pkg::PM_EXT_OUT;
        ecp_pkg::MODE5_RC_OUT:  next_mode = ecp_pkg::PM_RC_OUT;
        ecp_pkg::MODE5_RC_IO:   next_mode = ecp_pkg::PM_RC_IO;
        ecp_pkg::MODE5_XTAL:    next_mode = ecp_pkg::PM_XTAL;
        ecp_pkg::MODE5_FAST:    next_mode = ecp_pkg::PM_FAST_XTAL;
        default:                next_mode = ecp_pkg::PM_OTHER;
      endcase
    else if (osc[ecp_pkg::MODE_LSB + 1 +: 3] == ecp_pkg::MODE4_FAST_TOP)
      next_mode = ecp_pkg::PM_FAST_XTAL;
    else
      case (osc[ecp_pkg::MODE_LSB +: 4])
        ecp_pkg::MODE4_EXT_IO_PLL16: next_mode = ecp_pkg::PM_EXT_IO_PLL16;
        ecp_pkg::MODE4_EXT_IO:       next_mode = ecp_pkg::PM_EXT_IO;
        ecp_pkg::MODE4_EXT_OUT:      next_mode = ecp_pkg::PM_EXT_OUT;
        ecp_pkg::MODE4_RC_OUT:       next_mode = ecp_pkg::PM_RC_OUT;
        ecp_pkg::MODE4_RC_IO:        next_mode = ecp_pkg::PM_RC_IO;
        ecp_pkg::MODE4_XTAL_PLL16:   next_mode = ecp_pkg::PM_XTAL_PLL16;
        ecp_pkg::MODE4_XTAL:         next_mode = ecp_pkg::PM_XTAL;
        default:                     next_mode = ecp_pkg::PM_OTHER;
      endcase
  end

  // system-operation outputs from the configuration words
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      CLK_SWITCH_EN  <= 1'b0;
      FAIL_SAFE_EN   <= 1'b0;
      STARTUP_SOURCE <= ecp_pkg::SRC_PRIMARY;
      PRIMARY_MODE   <= ecp_pkg::PM_OTHER;
      PLL_X16        <= 1'b0;
      CODE_PROTECTED <= 1'b0;
    end
    else
    begin
      CLK_SWITCH_EN  <= sw_field == ecp_pkg::CKSM_FSCM_OFF || sw_field == ecp_pkg::CKSM_BOTH_ON;
      FAIL_SAFE_EN   <= sw_field == ecp_pkg::CKSM_BOTH_ON;
      STARTUP_SOURCE <= osc[ecp_pkg::SRC_LSB +: 2];
      PRIMARY_MODE   <= next_mode;
      PLL_X16        <= next_mode == ecp_pkg::PM_EXT_IO_PLL16 || next_mode == ecp_pkg::PM_XTAL_PLL16;
      CODE_PROTECTED <= protect;
    end
  end

  // clock over four on the second oscillator pin in out modes
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      div             <= '0;
      SECOND_OSC_OUT  <= 1'b0;
      SECOND_OSC_OE_N <= 1'b1;
    end
    else
    begin
      div             <= div + 2'h1;
      SECOND_OSC_OUT  <= div[1];
      SECOND_OSC_OE_N <= !(next_mode == ecp_pkg::PM_EXT_OUT || next_mode == ecp_pkg::PM_RC_OUT);
    end
  end
endmodule // ecp_device
`default_nettype wire

//--- ecp_link_if.sv
`default_nettype none
interface ecp_link_if;
  logic        cmd_valid;
  logic [2:0]  cmd_op;
  logic [11:0] cmd_addr;
  logic [15:0] cmd_data;
  logic        wd_valid;
  logic [15:0] wd_data;
  logic        rsp_valid;
  logic        rsp_ok;
  logic [15:0] rsp_data;

  modport dev  (input cmd_valid, cmd_op, cmd_addr, cmd_data, wd_valid, wd_data,
                output rsp_valid, rsp_ok, rsp_data);
  modport prog (output cmd_valid, cmd_op, cmd_addr, cmd_data, wd_valid, wd_data,
                input rsp_valid, rsp_ok, rsp_data);
endinterface
`default_nettype wire

//--- ecp_link_monitor.sv
`default_nettype none
module ecp_link_monitor (
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_op,
  input wire logic [11:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic        wd_valid,
  input wire logic [15:0] wd_data,
  input wire logic        rsp_valid,
  input wire logic        rsp_ok,
  input wire logic [15:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]  beats;
  logic [11:0] last_row;
  default clocking mon_cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // row data beats since the latest command
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N || cmd_valid) beats <= 5'h00;
    else if (wd_valid) beats <= beats + 5'h01;
  end
  // address of the latest row command
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N) last_row <= 12'h000;
    else if (cmd_valid && cmd_op == ecp_pkg::OP_ROW_PROG) last_row <= cmd_addr;
  end
  // sixteen back-to-back beats of one row
  sequence row_beats_s;
    wd_valid[*8] ##1 wd_valid[*8];
  endsequence
  // one response pulse
  sequence single_rsp_s;
    rsp_valid ##1 !rsp_valid;
  endsequence
  a_row_beat_count: assert property (cmd_valid && cmd_op == ecp_pkg::OP_ROW_PROG |-> ##1 row_beats_s ##1 single_rsp_s)
    else $error("row command not followed by sixteen beats and one response");
  a_rsp_after_cmd: assert property (cmd_valid && cmd_op != ecp_pkg::OP_ROW_PROG |-> ##1 single_rsp_s)
    else $error("command without a single response");
  a_cmd_spacing: assert property (cmd_valid |-> ##1 !cmd_valid[*2])
    else $error("second command while one is outstanding");
  a_rsp_caused: assert property (rsp_valid |-> $past(cmd_valid) || ($past(wd_valid) && $past(beats) == 5'h0f))
    else $error("response without a command");
  a_row_stride: assert property (cmd_valid && cmd_op == ecp_pkg::OP_ROW_PROG |->
    cmd_addr == 12'h000 || cmd_addr == last_row + ecp_pkg::ROW_STRIDE)
    else $error("row address not zero or previous plus stride");
  a_erase_then_write: assert property (cmd_valid && cmd_op == ecp_pkg::OP_CFG_ERASE |->
    ##3 (cmd_valid && cmd_op == ecp_pkg::OP_CFG_WRITE && cmd_addr[2:0] == $past(cmd_addr[2:0], 3)))
    else $error("erase of a word not followed by its write");
  a_beat_bound: assert property (wd_valid |-> beats < 5'h10)
    else $error("more than sixteen beats in one row");
  a_write_rsp_zero: assert property (rsp_valid && $past(wd_valid) |-> rsp_data == 16'h0000)
    else $error("row response carries data");
endmodule // ecp_link_monitor
`default_nettype wire

//--- ecp_pkg.sv
`default_nettype none
package ecp_pkg;
  // store geometry
  localparam int ROW_WORDS   = 16;
  localparam int PANEL_ROWS  = 128;
  localparam int PANEL_WORDS = 2048;
  localparam int CFG_WORDS   = 7;
  localparam int CODE_WORDS  = 256;
  localparam logic [11:0] ROW_STRIDE = 12'h020;
  localparam logic [11:0] ADDR_ZERO  = 12'h000;
  localparam logic [3:0]  LAST_BEAT  = 4'hf;

  // link commands
  typedef enum logic [2:0] {
    OP_ROW_PROG  = 3'h0,
    OP_DATA_READ = 3'h1,
    OP_PM_READ   = 3'h2,
    OP_PM_WRITE  = 3'h3,
    OP_CFG_ERASE = 3'h4,
    OP_CFG_WRITE = 3'h5,
    OP_CFG_READ  = 3'h6
  } ecp_op_e;

  // configuration words and fields
  localparam logic [2:0]  CFG_OSC       = 3'h0;
  localparam logic [2:0]  CFG_PROTECT   = 3'h6;
  localparam int          PROTECT_BIT   = 0;
  localparam int          MODE_LSB      = 0;
  localparam int          SRC_LSB       = 8;
  localparam int          SWITCH_LSB    = 14;
  localparam logic [15:0] CFG_ERASED    = 16'hffff;
  localparam logic [1:0]  CKSM_FSCM_OFF = 2'h1;
  localparam logic [1:0]  CKSM_BOTH_ON  = 2'h0;

  // primary oscillator mode codes, four-bit layouts
  localparam logic [3:0] MODE4_EXT_IO_PLL16 = 4'hf;
  localparam logic [3:0] MODE4_EXT_IO       = 4'hc;
  localparam logic [3:0] MODE4_EXT_OUT      = 4'hb;
  localparam logic [3:0] MODE4_RC_OUT       = 4'h9;
  localparam logic [3:0] MODE4_RC_IO        = 4'h8;
  localparam logic [3:0] MODE4_XTAL_PLL16   = 4'h7;
  localparam logic [3:0] MODE4_XTAL         = 4'h4;
  localparam logic [2:0] MODE4_FAST_TOP     = 3'h1;
  // five-bit layout
  localparam logic [4:0] MODE5_EXT_IO  = 5'h0c;
  localparam logic [4:0] MODE5_EXT_OUT = 5'h0b;
  localparam logic [4:0] MODE5_RC_OUT  = 5'h09;
  localparam logic [4:0] MODE5_RC_IO   = 5'h08;
  localparam logic [4:0] MODE5_XTAL    = 5'h04;
  localparam logic [4:0] MODE5_FAST    = 5'h02;
  localparam int         LAYOUT_WIDE   = 2;

  typedef enum logic [3:0] {
    PM_OTHER, PM_EXT_IO_PLL16, PM_EXT_IO, PM_EXT_OUT, PM_RC_OUT,
    PM_RC_IO, PM_XTAL_PLL16, PM_XTAL, PM_FAST_XTAL
  } ecp_pmode_e;

  typedef enum logic [1:0] {
    SRC_LP32K = 2'h0, SRC_FRC = 2'h1, SRC_LPRC = 2'h2, SRC_PRIMARY = 2'h3
  } ecp_src_e;

  // programmer user registers
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ROWS     = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_BUF_ADDR = 8'h0c;
  localparam logic [7:0] REG_BUF_DATA = 8'h10;
  localparam logic [7:0] REG_CFG_CMD  = 8'h14;
  localparam logic [7:0] REG_PM_CMD   = 8'h18;
  localparam logic [7:0] REG_RESULT   = 8'h1c;
  localparam logic [7:0] REG_CFG_RD   = 8'h20;
  localparam int CTRL_PROG = 0;
  localparam int CTRL_VDAT = 1;
  localparam int CTRL_VCOD = 2;
  localparam logic [7:0] ROWS_RESET = 8'h80;

  // programmer states, gray along the usual path
  typedef enum logic [1:0] {
    P_IDLE = 2'b00, P_CMD = 2'b01, P_DATA = 2'b11, P_WAIT = 2'b10
  } ecp_pstate_e;

  typedef enum logic [2:0] {
    J_PROG, J_VDATA, J_VCODE, J_CFG, J_PMW, J_CFGRD
  } ecp_job_e;

  typedef enum logic {D_IDLE = 1'b0, D_ROW = 1'b1} ecp_dstate_e;
endpackage
`default_nettype wire

//--- ecp_programmer.sv
`default_nettype none
module ecp_programmer (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output var  logic [31:0] RDATA,
  ecp_link_if.prog         LINK
);
  logic [15:0] buffer [ecp_pkg::PANEL_WORDS];
  ecp_pkg::ecp_pstate_e state;
  ecp_pkg::ecp_job_e    job;
  logic [7:0]  rows_reg;
  logic [7:0]  rows_left_counter;
  logic [11:0] target_row_address;
  logic [3:0]  beat;
  logic [10:0] buf_ptr;
  logic [10:0] word_idx;
  logic        erase_phase;
  logic [2:0]  cfg_idx;
  logic [15:0] cfg_val;
  logic [11:0] pm_addr;
  logic        busy;
  logic        done;
  logic        fail;
  logic [16:0] result;
  logic        idle_wr;
  logic        vjob;

  assign busy     = state != ecp_pkg::P_IDLE;
  assign idle_wr  = WR && !busy;
  assign word_idx = {target_row_address[11:5], beat};
  assign vjob     = job == ecp_pkg::J_VDATA || job == ecp_pkg::J_VCODE;

  // host buffer fill and user settings
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      rows_reg <= ecp_pkg::ROWS_RESET;
      buf_ptr  <= '0;
    end
    else if (WR)
      case (ADDR)
        ecp_pkg::REG_ROWS:     rows_reg <= WDATA[7:0];
        ecp_pkg::REG_BUF_ADDR: buf_ptr  <= WDATA[10:0];
        ecp_pkg::REG_BUF_DATA: buf_ptr  <= buf_ptr + 11'h001;
        default:               buf_ptr  <= buf_ptr;
      endcase
  end

  // buffer array write port
  always_ff @(posedge SYS_CLK)
  begin
    if (WR && ADDR == ecp_pkg::REG_BUF_DATA)
      buffer[buf_ptr] <= WDATA[15:0];
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N || !RD)
      RDATA <= '0;
    else
      case (ADDR)
        ecp_pkg::REG_ROWS:     RDATA <= {24'h000000, rows_reg};
        ecp_pkg::REG_STATUS:   RDATA <= {16'h0000, rows_left_counter, 5'h00, fail, done, busy};
        ecp_pkg::REG_BUF_ADDR: RDATA <= {21'h0, buf_ptr};
        ecp_pkg::REG_BUF_DATA: RDATA <= {16'h0000, buffer[buf_ptr]};
        ecp_pkg::REG_RESULT:   RDATA <= {15'h0, result};
        default:               RDATA <= '0;
      endcase
  end

  // command sequencer: one command at a time
  always_ff @(posedge SYS_CLK)
  begin
    LINK.cmd_valid <= 1'b0;
    LINK.wd_valid  <= 1'b0;
    if (!RESET_N)
    begin
      state              <= ecp_pkg::P_IDLE;
      job                <= ecp_pkg::J_PROG;
      rows_left_counter  <= '0;
      target_row_address <= ecp_pkg::ADDR_ZERO;
      beat               <= '0;
      erase_phase        <= 1'b0;
      cfg_idx            <= '0;
      cfg_val            <= '0;
      pm_addr            <= '0;
      done               <= 1'b0;
      fail               <= 1'b0;
      result             <= '0;
      LINK.cmd_op        <= ecp_pkg::OP_ROW_PROG;
      LINK.cmd_addr      <= '0;
      LINK.cmd_data      <= '0;
      LINK.wd_data       <= '0;
    end
    else
      case (state)
        ecp_pkg::P_IDLE:
          if (idle_wr)
          begin
            done               <= 1'b0;
            fail               <= 1'b0;
            beat               <= '0;
            rows_left_counter  <= rows_reg;
            target_row_address <= ecp_pkg::ADDR_ZERO;
            state              <= ecp_pkg::P_CMD;
            case (ADDR)
              ecp_pkg::REG_CTRL:
              begin
                if (WDATA[ecp_pkg::CTRL_PROG])
                  job <= ecp_pkg::J_PROG;
                else if (WDATA[ecp_pkg::CTRL_VDAT])
                  job <= ecp_pkg::J_VDATA;
                else if (WDATA[ecp_pkg::CTRL_VCOD])
                  job <= ecp_pkg::J_VCODE;
                else
                  state <= ecp_pkg::P_IDLE;
                if (rows_reg == 8'h00)
                begin
                  state <= ecp_pkg::P_IDLE;
                  done  <= 1'b1;
                end
              end
              ecp_pkg::REG_CFG_CMD:
              begin
                job         <= ecp_pkg::J_CFG;
                erase_phase <= 1'b1;
                cfg_idx     <= WDATA[18:16];
                cfg_val     <= WDATA[15:0];
              end
              ecp_pkg::REG_CFG_RD:
              begin
                job     <= ecp_pkg::J_CFGRD;
                cfg_idx <= WDATA[2:0];
              end
              ecp_pkg::REG_PM_CMD:
              begin
                job     <= ecp_pkg::J_PMW;
                cfg_val <= WDATA[15:0];
                pm_addr <= {WDATA[26:16], 1'b0};
              end
              default:
                state <= ecp_pkg::P_IDLE;
            endcase
          end
        ecp_pkg::P_CMD:
        begin
          LINK.cmd_valid <= 1'b1;
          LINK.cmd_data  <= cfg_val;
          LINK.cmd_addr  <= {word_idx, 1'b0};
          state          <= ecp_pkg::P_WAIT;
          case (job)
            ecp_pkg::J_PROG:
            begin
              LINK.cmd_op   <= ecp_pkg::OP_ROW_PROG;
              LINK.cmd_addr <= target_row_address;
              state         <= ecp_pkg::P_DATA;
            end
            ecp_pkg::J_VDATA: LINK.cmd_op <= ecp_pkg::OP_DATA_READ;
            ecp_pkg::J_VCODE: LINK.cmd_op <= ecp_pkg::OP_PM_READ;
            ecp_pkg::J_CFG:
            begin
              LINK.cmd_op   <= erase_phase ? ecp_pkg::OP_CFG_ERASE : ecp_pkg::OP_CFG_WRITE;
              LINK.cmd_addr <= {9'h000, cfg_idx};
            end
            ecp_pkg::J_CFGRD:
            begin
              LINK.cmd_op   <= ecp_pkg::OP_CFG_READ;
              LINK.cmd_addr <= {9'h000, cfg_idx};
            end
            default:
            begin
              LINK.cmd_op   <= ecp_pkg::OP_PM_WRITE;
              LINK.cmd_addr <= pm_addr;
            end
          endcase
        end
        ecp_pkg::P_DATA:
        begin
          LINK.wd_valid <= 1'b1;
          LINK.wd_data  <= buffer[word_idx];
          beat          <= beat + 4'h1;
          if (beat == ecp_pkg::LAST_BEAT)
            state <= ecp_pkg::P_WAIT;
        end
        ecp_pkg::P_WAIT:
          if (LINK.rsp_valid)
          begin
            result <= {LINK.rsp_ok, LINK.rsp_data};
            state  <= ecp_pkg::P_IDLE;
            if (vjob && (!LINK.rsp_ok || LINK.rsp_data != buffer[word_idx]))
              fail <= 1'b1;
            if (job == ecp_pkg::J_PROG && !LINK.rsp_ok)
            begin
              fail <= 1'b1;
              done <= 1'b1;
            end
            else if (job == ecp_pkg::J_PROG || (vjob && beat == ecp_pkg::LAST_BEAT))
            begin
              rows_left_counter <= rows_left_counter - 8'h01;
              beat              <= '0;
              if (rows_left_counter == 8'h01)
                done <= 1'b1;
              else
              begin
                target_row_address <= target_row_address + ecp_pkg::ROW_STRIDE;
                state              <= ecp_pkg::P_CMD;
              end
            end
            else if (vjob)
            begin
              beat  <= beat + 4'h1;
              state <= ecp_pkg::P_CMD;
            end
            else if (job == ecp_pkg::J_CFG && erase_phase)
            begin
              erase_phase <= 1'b0;
              state       <= ecp_pkg::P_CMD;
            end
            else
              done <= 1'b1;
          end
        default:
          state <= ecp_pkg::P_IDLE;
      endcase
  end
endmodule // ecp_programmer
`default_nettype wire

//--- eeprom_and_config_programming_tb.sv
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module eeprom_and_config_programming_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ROWS = 32;
  localparam logic [3:0] CODES [0:8] = '{4'hf, 4'h8, 4'h7, 4'h2, 4'h3, 4'hb, 4'h9, 4'hc, 4'h4};
  logic        sys_clk, reset_n, wr, rd;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, seed, st;
  logic        sw_en, fs_en, pll, osc_out, osc_oe_n, prot, osc0;
  logic [1:0]  src;
  logic [3:0]  pmode;
  logic [15:0] cw;
  logic [15:0] mem [0:2047];
  int          err_total, checks_done, row_cnt, wd_idx;
  ecp_link_if lnk ();
  ecp_programmer ecp_programmer_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .LINK(lnk.prog));
  ecp_device #(.DATA_ROWS(ROWS), .OSC_LAYOUT(0)) ecp_device_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .LINK(lnk.dev), .CLK_SWITCH_EN(sw_en), .FAIL_SAFE_EN(fs_en), .STARTUP_SOURCE(src), .PRIMARY_MODE(pmode),
    .PLL_X16(pll), .SECOND_OSC_OUT(osc_out), .SECOND_OSC_OE_N(osc_oe_n), .CODE_PROTECTED(prot));
  ecp_link_monitor ecp_link_monitor_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n), .cmd_valid(lnk.cmd_valid),
    .cmd_op(lnk.cmd_op), .cmd_addr(lnk.cmd_addr), .cmd_data(lnk.cmd_data), .wd_valid(lnk.wd_valid),
    .wd_data(lnk.wd_data), .rsp_valid(lnk.rsp_valid), .rsp_ok(lnk.rsp_ok), .rsp_data(lnk.rsp_data));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected decoded primary mode
  function automatic ecp_pkg::ecp_pmode_e exp_mode(input logic [3:0] f);
    if (f[3:1] == 3'h1) return ecp_pkg::PM_FAST_XTAL;
    case (f)
      4'hf: return ecp_pkg::PM_EXT_IO_PLL16;
      4'hc: return ecp_pkg::PM_EXT_IO;
      4'hb: return ecp_pkg::PM_EXT_OUT;
      4'h9: return ecp_pkg::PM_RC_OUT;
      4'h8: return ecp_pkg::PM_RC_IO;
      4'h7: return ecp_pkg::PM_XTAL_PLL16;
      4'h4: return ecp_pkg::PM_XTAL;
      default: return ecp_pkg::PM_OTHER;
    endcase
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // start a job and poll status until idle, bounded
  task automatic run_job(input logic [7:0] a, input logic [31:0] d, output logic [31:0] s);
    int n;
    wr_reg(a, d);
    n = 0;
    do
    begin
      rd_reg(ecp_pkg::REG_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 4000);
    if (s[0] !== 1'b0)
    begin
      err_total++;
      $display("[ERR] %0t job never finished", $time);
      test_done();
    end
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // clock source
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // row commands and data beats seen on the link
  always @(posedge sys_clk)
  begin
    if (lnk.cmd_valid === 1'b1 && lnk.cmd_op === ecp_pkg::OP_ROW_PROG)
    begin
      `CHK(lnk.cmd_addr, 12'(row_cnt * 32))
      row_cnt++;
    end
    if (lnk.wd_valid === 1'b1)
    begin
      `CHK(lnk.wd_data, mem[wd_idx])
      wd_idx++;
    end
  end
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    seed = 32'h783d27ab;
    {err_total, checks_done, row_cnt, wd_idx} = '0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 `CHK({sw_en, fs_en, src, pmode, pll, osc_oe_n, prot}, {4'h3, ecp_pkg::PM_EXT_IO_PLL16, 3'h6})
    rd_reg(ecp_pkg::REG_ROWS, st);
    `CHK(st[7:0], 8'h80)
    rd_reg(8'h3c, st);
    `CHK(st, 32'h0)
    // random row data, one row beyond the panel
    wr_reg(ecp_pkg::REG_BUF_ADDR, 32'h0);
    for (int i = 0; i < (ROWS + 1) * 16; i++)
    begin
      seed = lfsr(seed);
      mem[i] = seed[15:0];
      wr_reg(ecp_pkg::REG_BUF_DATA, {16'h0, seed[15:0]});
    end
    wr_reg(ecp_pkg::REG_ROWS, 32'(ROWS));
    run_job(ecp_pkg::REG_CTRL, 32'h1, st);
    `CHK({st[15:8], st[2]}, {8'h00, 1'b0})
    `CHK(row_cnt, ROWS)
    run_job(ecp_pkg::REG_CTRL, 32'h2, st);
    `CHK(st[2], 1'b0)
    // a corrupted buffer word must be caught
    wr_reg(ecp_pkg::REG_BUF_ADDR, 32'h4d);
    wr_reg(ecp_pkg::REG_BUF_DATA, {16'h0, ~mem[77]});
    run_job(ecp_pkg::REG_CTRL, 32'h2, st);
    `CHK(st[2], 1'b1)
    wr_reg(ecp_pkg::REG_BUF_ADDR, 32'h4d);
    wr_reg(ecp_pkg::REG_BUF_DATA, {16'h0, mem[77]});
    // the row past the panel is refused
    wr_reg(ecp_pkg::REG_ROWS, 32'(ROWS + 1));
    {row_cnt, wd_idx} = '0;
    run_job(ecp_pkg::REG_CTRL, 32'h1, st);
    `CHK({st[15:8], st[2]}, {8'h01, 1'b1})
    // every mode code, all switch and source values
    for (int k = 0; k < 9; k++)
    begin
      seed = lfsr(seed);
      cw = {2'(k), seed[13:10], 2'(k + 1), seed[7:4], CODES[k]};
      run_job(ecp_pkg::REG_CFG_CMD, {13'h0, ecp_pkg::CFG_OSC, cw}, st);
      `CHK({sw_en, fs_en}, {~cw[15], cw[15:14] == 2'h0})
      `CHK(src, cw[9:8])
      `CHK(pmode, exp_mode(cw[3:0]))
      `CHK({pll, osc_oe_n}, {cw[3:0] == 4'hf || cw[3:0] == 4'h7, !(cw[3:0] == 4'hb || cw[3:0] == 4'h9)})
      if (cw[3:0] == 4'hb || cw[3:0] == 4'h9)
      begin
        osc0 = osc_out;
        repeat (2) @(posedge sys_clk);
        #1 `CHK(osc_out, ~osc0)
      end
      run_job(ecp_pkg::REG_CFG_RD, 32'h0, st);
      rd_reg(ecp_pkg::REG_RESULT, st);
      `CHK(st[16:0], {1'b1, cw})
    end
    // protect bit locks program memory writes
    run_job(ecp_pkg::REG_CFG_CMD, {13'h0, ecp_pkg::CFG_PROTECT, 16'hfffe}, st);
    `CHK(prot, 1'b1)
    // code read-back of one row is refused while protected
    wr_reg(ecp_pkg::REG_ROWS, 32'h1);
    run_job(ecp_pkg::REG_CTRL, 32'h4, st);
    `CHK(st[2], 1'b1)
    run_job(ecp_pkg::REG_PM_CMD, {5'h0, 11'h005, 16'h1234}, st);
    rd_reg(ecp_pkg::REG_RESULT, st);
    `CHK(st[16], 1'b0)
    run_job(ecp_pkg::REG_CFG_CMD, {13'h0, ecp_pkg::CFG_PROTECT, 16'hffff}, st);
    `CHK(prot, 1'b0)
    run_job(ecp_pkg::REG_PM_CMD, {5'h0, 11'h005, 16'h1234}, st);
    rd_reg(ecp_pkg::REG_RESULT, st);
    `CHK(st[16], 1'b1)
    // code read-back of the first row once written
    for (int i = 0; i < 16; i++)
      run_job(ecp_pkg::REG_PM_CMD, {5'h0, 11'(i), mem[i]}, st);
    run_job(ecp_pkg::REG_CTRL, 32'h4, st);
    `CHK(st[2], 1'b0)
    // there is no eighth configuration word
    run_job(ecp_pkg::REG_CFG_RD, 32'h7, st);
    rd_reg(ecp_pkg::REG_RESULT, st);
    `CHK(st[16], 1'b0)
    test_done();
  end
endmodule // eeprom_and_config_programming_tb
`default_nettype wire
